// file: src/mas_defs.vh
`ifndef MAS_DEFS_VH
`define MAS_DEFS_VH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define MAS_OFF_CTRL 8'h00
`define MAS_OFF_CHDIS0 8'h04
`define MAS_OFF_CHDIS1 8'h08
`define MAS_OFF_STATUS 8'h0C
`define MAS_OFF_FLAG 8'h10
`define MAS_OFF_MASK 8'h14
`define MAS_RES_SEL 2'h1
// ****************************************
// control field positions and reset values
// ****************************************
`define MAS_CTRL_EN 0
`define MAS_CTRL_ONESHOT 1
`define MAS_CTRL_AVG 2
`define MAS_CTRL_SEED 3
`define MAS_CTRL_SPD_LO 4
`define MAS_CTRL_SPD_HI 5
`define MAS_CTRL_IBAT 6
`define MAS_CTRL_INDDIS 7
`define MAS_CTRL_RST 8'h00
`define MAS_CHDIS_RST 8'h00
`define MAS_MASK_RST 32'h00000000
// ****************************************
// channel map
// ****************************************
`define MAS_NCH 16
`define MAS_CH_NONE 5'h10
`define MAS_CH_CHG_CUR 4'h1
`define MAS_CH_THERM 4'hA
// ****************************************
// timing
// ****************************************
`define MAS_CLK_MHZ 250
`define MAS_ALERT_US 256
`define MAS_ALERT_CYC (`MAS_ALERT_US * `MAS_CLK_MHZ)
`define MAS_BLINK_HALF_MS 500
`define MAS_BLINK_HALF_CYC (`MAS_BLINK_HALF_MS * `MAS_CLK_MHZ * 1000)
`endif

// file: src/mas_alert_pulse.v
`timescale 1ns/1ns
`default_nettype none
`include "mas_defs.vh"
module mas_alert_pulse #(
	parameter [31:0] WIDTH_CYC = `MAS_ALERT_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire trig,
	output wire alert_n
);
	reg [31:0] cnt_reg;
	reg busy_reg;
	// ****************************************
	// fixed-width low pulse, retrigger merged
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 32'h00000000;
			busy_reg <= 1'b0;
		end else if (!busy_reg) begin
			if (trig) begin
				busy_reg <= 1'b1;
				cnt_reg <= 32'h00000000;
			end
		end else if (cnt_reg == WIDTH_CYC - 32'h00000001) begin
			busy_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + 32'h00000001;
		end
	end
	assign alert_n = ~busy_reg;
endmodule // mas_alert_pulse
`default_nettype wire

// file: src/mas_core.v
// Operation
// - no conversion unless the enable bit is set by software
// - rate bit picks continuous or one-shot; one-shot clears enable at cycle end
// - averaging off at reset, own enable; seed bit picks stored or fresh start
// - convert only with adapter, bus or battery above its valid level
// - enable before supplies good stays pending until one qualifies
// - enable works in input high-impedance mode too
// - battery-only with thermistor channel on needs the higher battery level
// - speed change aborts the current channel and reconverts it
// - all channels on by default; disabled ones keep last result or zero
// - channel disabled mid-conversion finishes, then is skipped
// - all channels disabled: idle, restart when any is re-enabled
// - one-shot end sets done status, flag, alert; continuous keeps them zero
// - faults never stop conversion; clearing enable, losing all supplies or source detection does
// - adapter plug-in suspends conversion until source detection completes
// - thermistor channel enabled turns on the bias regulator while the enable bit is set
// - charge current reads zero in trickle, supplement or charge disabled
// - battery-only: current sense amplifier off unless its enable is set
// - indicator pin low while charging, released otherwise or when disabled
// - indicator blinks at 1 Hz while charging is fault-suspended
// - each unmasked alert event gives a 256 us low pulse; events during a pulse merge into it
// - alert sources are the status inputs plus conversion done
// - per source live status, rising-edge flag cleared on read, and mask
`timescale 1ns/1ns
`default_nettype none
`include "mas_defs.vh"
module mas_core #(
	parameter NSRC = 16,
	parameter [31:0] ALERT_CYC = `MAS_ALERT_CYC,
	parameter [31:0] BLINK_CYC = `MAS_BLINK_HALF_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire adapter_valid_in,
	input wire bus_valid_in,
	input wire bat_above_low_in,
	input wire bat_above_high_in,
	input wire battery_only_in,
	input wire source_detect_busy_in,
	input wire input_high_impedance_mode_in,
	input wire charging_in,
	input wire charge_fault_suspend_in,
	input wire trickle_in,
	input wire supplement_in,
	input wire charge_disabled_in,
	input wire [NSRC-1:0] alert_status_in,
	output reg conv_start,
	output reg conv_abort,
	output reg [3:0] conv_channel,
	output reg [1:0] conv_speed,
	input wire conv_done,
	input wire [15:0] conv_data,
	output reg bias_regulator_output_en,
	output reg current_sense_amplifier_en,
	output wire indicator_o,
	output reg indicator_oe,
	output wire alert_n
);
	localparam NPIN = 12 + NSRC;
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_START = 2'h1;
	localparam [1:0] ST_CONV = 2'h2;
	localparam [1:0] ST_END = 2'h3;
	localparam [31:0] MASK_RST = `MAS_MASK_RST;

	// first enabled channel at or above a start index
	function [4:0] mas_next;
		input [15:0] dis;
		input [4:0] from;
		integer i;
		begin
			mas_next = `MAS_CH_NONE;
			for (i = `MAS_NCH - 1; i >= 0; i = i - 1) begin
				if (!dis[i] && i >= from)
					mas_next = i[4:0];
			end
		end
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	wire [NPIN-1:0] pin_raw;
	reg [NPIN-1:0] pin_s1_reg;
	reg [NPIN-1:0] pin_s2_reg;
	assign pin_raw = {alert_status_in, charge_disabled_in, supplement_in, trickle_in,
		charge_fault_suspend_in, charging_in, input_high_impedance_mode_in,
		source_detect_busy_in, battery_only_in, bat_above_high_in,
		bat_above_low_in, bus_valid_in, adapter_valid_in};
	// two flops per pin
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_reg <= {NPIN{1'b0}};
			pin_s2_reg <= {NPIN{1'b0}};
		end else begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
		end
	end
	wire adapter_ok = pin_s2_reg[0];
	wire bus_ok = pin_s2_reg[1];
	wire bat_low_ok = pin_s2_reg[2];
	wire bat_high_ok = pin_s2_reg[3];
	wire bat_only = pin_s2_reg[4];
	wire detect_busy = pin_s2_reg[5];
	wire input_high_impedance_mode = pin_s2_reg[6];
	wire charging = pin_s2_reg[7];
	wire fault_susp = pin_s2_reg[8];
	wire trickle = pin_s2_reg[9];
	wire supplement = pin_s2_reg[10];
	wire chg_dis = pin_s2_reg[11];
	wire [NSRC-1:0] src_stat = pin_s2_reg[NPIN-1:12];

	// ****************************************
	// registers and bus decode
	// ****************************************
	reg [7:0] ctrl_reg;
	reg [7:0] chdis0_reg;
	reg [7:0] chdis1_reg;
	reg [NSRC:0] mask_reg;
	reg [NSRC:0] flag_reg;
	reg [NSRC:0] stat_prev_reg;
	reg done_stat_reg;
	reg [15:0] result_mem [0:15];
	reg [15:0] seeded_reg;
	reg [1:0] state_reg;
	reg [4:0] ch_reg;
	wire [15:0] ch_dis = {chdis1_reg, chdis0_reg};
	wire conv_en = ctrl_reg[`MAS_CTRL_EN];
	wire oneshot = ctrl_reg[`MAS_CTRL_ONESHOT];
	wire avg_en = ctrl_reg[`MAS_CTRL_AVG];
	wire seed_fresh = ctrl_reg[`MAS_CTRL_SEED];
	wire [1:0] speed = ctrl_reg[`MAS_CTRL_SPD_HI:`MAS_CTRL_SPD_LO];
	wire ind_dis = ctrl_reg[`MAS_CTRL_INDDIS];
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire is_res = (paddr[7:6] == `MAS_RES_SEL);
	wire mapped = is_res || paddr == `MAS_OFF_CTRL || paddr == `MAS_OFF_CHDIS0 ||
		paddr == `MAS_OFF_CHDIS1 || paddr == `MAS_OFF_STATUS ||
		paddr == `MAS_OFF_FLAG || paddr == `MAS_OFF_MASK;
	wire wr = access & pwrite & mapped;
	wire rd_flag = access & ~pwrite & (paddr == `MAS_OFF_FLAG);
	wire cycle_end = (state_reg == ST_END);
	wire [NSRC:0] stat_vec = {done_stat_reg, src_stat};
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

	// read data captured in setup, stable through access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup) begin
			prdata <= 32'h00000000;
			if (is_res)
				prdata <= {16'h0000, result_mem[paddr[5:2]]};
			else case (paddr)
				`MAS_OFF_CTRL: prdata <= {24'h000000, ctrl_reg};
				`MAS_OFF_CHDIS0: prdata <= {24'h000000, chdis0_reg};
				`MAS_OFF_CHDIS1: prdata <= {24'h000000, chdis1_reg};
				`MAS_OFF_STATUS: prdata <= {{(31-NSRC){1'b0}}, stat_vec};
				`MAS_OFF_FLAG: prdata <= {{(31-NSRC){1'b0}}, flag_reg};
				`MAS_OFF_MASK: prdata <= {{(31-NSRC){1'b0}}, mask_reg};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// control writes; one-shot end clears enable, a write in that cycle wins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `MAS_CTRL_RST;
			chdis0_reg <= `MAS_CHDIS_RST;
			chdis1_reg <= `MAS_CHDIS_RST;
			mask_reg <= MASK_RST[NSRC:0];
		end else begin
			if (cycle_end && oneshot)
				ctrl_reg[`MAS_CTRL_EN] <= 1'b0;
			if (wr && paddr == `MAS_OFF_CTRL)
				ctrl_reg <= pwdata[7:0];
			if (wr && paddr == `MAS_OFF_CHDIS0)
				chdis0_reg <= pwdata[7:0];
			if (wr && paddr == `MAS_OFF_CHDIS1)
				chdis1_reg <= pwdata[7:0];
			if (wr && paddr == `MAS_OFF_MASK)
				mask_reg <= pwdata[NSRC:0];
		end
	end

	// ****************************************
	// conversion qualification
	// ****************************************
	wire therm_on = ~ch_dis[`MAS_CH_THERM];
	wire bat_ok = (bat_only && therm_on) ? bat_high_ok : bat_low_ok;
	wire supply_ok = adapter_ok | bus_ok | bat_ok;
	// faults are not part of this gate by design
	wire run_ok = conv_en & supply_ok & ~detect_busy;
	wire [4:0] first_ch = mas_next(ch_dis, 5'h00);
	wire [4:0] next_ch = mas_next(ch_dis, ch_reg + 5'h01);
	wire [15:0] old_res = result_mem[ch_reg[3:0]];
	wire [16:0] avg_sum = {1'b0, old_res} + {1'b0, conv_data};
	wire chg_zero = trickle | supplement | chg_dis;
	reg [15:0] store_val;
	// averaging and forced-zero selection of the stored value
	always @* begin
		store_val = conv_data;
		if (avg_en && (seeded_reg[ch_reg[3:0]] || !seed_fresh))
			store_val = avg_sum[16:1];
		if (ch_reg[3:0] == `MAS_CH_CHG_CUR && chg_zero)
			store_val = 16'h0000;
	end

	// ****************************************
	// channel sequencer
	// ****************************************
	integer k;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			ch_reg <= 5'h00;
			conv_start <= 1'b0;
			conv_abort <= 1'b0;
			conv_channel <= 4'h0;
			conv_speed <= 2'h0;
			seeded_reg <= 16'h0000;
			for (k = 0; k < `MAS_NCH; k = k + 1)
				result_mem[k] <= 16'h0000;
		end else begin
			conv_start <= 1'b0;
			conv_abort <= 1'b0;
			if (!avg_en)
				seeded_reg <= 16'h0000;
			case (state_reg)
				ST_IDLE: begin
					// nothing starts while every channel is disabled
					if (run_ok && first_ch != `MAS_CH_NONE) begin
						ch_reg <= first_ch;
						state_reg <= ST_START;
					end
				end
				ST_START: begin
					if (!conv_en) begin
						state_reg <= ST_IDLE;
					end else if (run_ok) begin
						conv_start <= 1'b1;
						conv_channel <= ch_reg[3:0];
						conv_speed <= speed;
						state_reg <= ST_CONV;
					end
				end
				ST_CONV: begin
					if (!conv_en) begin
						conv_abort <= 1'b1;
						state_reg <= ST_IDLE;
					end else if (!run_ok || speed != conv_speed) begin
						conv_abort <= 1'b1;
						state_reg <= ST_START;
					end else if (conv_done) begin
						// disabling mid-conversion still stores
						result_mem[ch_reg[3:0]] <= store_val;
						if (avg_en)
							seeded_reg[ch_reg[3:0]] <= 1'b1;
						if (next_ch == `MAS_CH_NONE) begin
							state_reg <= ST_END;
						end else begin
							ch_reg <= next_ch;
							state_reg <= ST_START;
						end
					end
				end
				ST_END: begin
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// status, flags and alert
	// ****************************************
	// done status only in one-shot; a new cycle or continuous mode clears it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_stat_reg <= 1'b0;
		end else if (cycle_end && oneshot) begin
			done_stat_reg <= 1'b1;
		end else if (!oneshot || (state_reg == ST_IDLE && run_ok)) begin
			done_stat_reg <= 1'b0;
		end
	end

	wire [NSRC:0] rise = stat_vec & ~stat_prev_reg;
	wire [NSRC:0] flag_clr = rd_flag ? prdata[NSRC:0] : {(NSRC+1){1'b0}};
	// flags latch rising edges; read clears only what was reported, set wins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_prev_reg <= {(NSRC+1){1'b0}};
			flag_reg <= {(NSRC+1){1'b0}};
		end else begin
			stat_prev_reg <= stat_vec;
			flag_reg <= (flag_reg & ~flag_clr) | rise;
			if (!oneshot)
				flag_reg[NSRC] <= 1'b0;
		end
	end

	wire alert_trig = |(rise & ~mask_reg);
	mas_alert_pulse #(
		.WIDTH_CYC(ALERT_CYC)
	) u_alert (
		.pclk(pclk),
		.presetn(presetn),
		.trig(alert_trig),
		.alert_n(alert_n)
	);

	// ****************************************
	// analog enables and charge indicator
	// ****************************************
	reg [31:0] blink_cnt_reg;
	reg blink_reg;
	// bias and current sense enables
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bias_regulator_output_en <= 1'b0;
			current_sense_amplifier_en <= 1'b0;
		end else begin
			bias_regulator_output_en <= conv_en & therm_on;
			current_sense_amplifier_en <= ~bat_only | ctrl_reg[`MAS_CTRL_IBAT];
		end
	end

	// half-period counter for the fault blink
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt_reg <= 32'h00000000;
			blink_reg <= 1'b0;
		end else if (!fault_susp) begin
			blink_cnt_reg <= 32'h00000000;
			blink_reg <= 1'b0;
		end else if (blink_cnt_reg == BLINK_CYC - 32'h00000001) begin
			blink_cnt_reg <= 32'h00000000;
			blink_reg <= ~blink_reg;
		end else begin
			blink_cnt_reg <= blink_cnt_reg + 32'h00000001;
		end
	end

	wire chg_active = charging & ~input_high_impedance_mode & ~bat_only & ~chg_dis;
	// open-drain: drive low only, enable high while pulling down
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			indicator_oe <= 1'b0;
		end else if (ind_dis) begin
			indicator_oe <= 1'b0;
		end else if (fault_susp) begin
			indicator_oe <= blink_reg;
		end else begin
			indicator_oe <= chg_active;
		end
	end
	assign indicator_o = 1'b0;
endmodule // mas_core
`default_nettype wire

// file: tb/mas_core_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "mas_defs.vh"
// ********
// port checker
// ********
module mas_core_monitor #(
	parameter [31:0] ALERT_CYC = `MAS_ALERT_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire conv_start,
	input wire source_detect_busy_in,
	input wire adapter_valid_in,
	input wire bus_valid_in,
	input wire bat_above_low_in,
	input wire charging_in,
	input wire charge_fault_suspend_in,
	input wire input_high_impedance_mode_in,
	input wire battery_only_in,
	input wire indicator_o,
	input wire indicator_oe,
	input wire current_sense_amplifier_en,
	input wire alert_n
);
	logic [31:0] low_cnt;
	logic [4:0] dry_h, busy_h, quiet_h, csa_h;
	// low-time counter and five-cycle input histories
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt <= 32'h0;
			dry_h <= 5'h0;
			busy_h <= 5'h0;
			quiet_h <= 5'h0;
			csa_h <= 5'h0;
		end else begin
			low_cnt <= alert_n ? 32'h0 : low_cnt + 32'h1;
			dry_h <= {dry_h[3:0], !(adapter_valid_in | bus_valid_in | bat_above_low_in)};
			busy_h <= {busy_h[3:0], source_detect_busy_in};
			quiet_h <= {quiet_h[3:0], (!charging_in | input_high_impedance_mode_in
				| battery_only_in) & !charge_fault_suspend_in};
			csa_h <= {csa_h[3:0], !battery_only_in};
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// alert stays low for the first stretch of the pulse
	sequence s_low8;
		!alert_n [*8];
	endsequence
	a_supply_gate: assert property (&dry_h |-> !conv_start)
		else $error("start with no supply valid");
	a_detect_hold: assert property (&busy_h |-> !conv_start)
		else $error("start during source detection");
	a_alert_hold: assert property ($fell(alert_n) |=> s_low8)
		else $error("alert pulse too short");
	a_alert_width: assert property ($rose(alert_n) |-> low_cnt == ALERT_CYC)
		else $error("alert pulse width wrong");
	a_alert_bound: assert property (low_cnt <= ALERT_CYC)
		else $error("alert pulse stretched");
	a_pin_low: assert property (!indicator_o)
		else $error("indicator drives high");
	a_indicator_quiet: assert property (&quiet_h |-> !indicator_oe)
		else $error("indicator low while not charging");
	a_sense_on: assert property (&csa_h |-> current_sense_amplifier_en)
		else $error("sense amplifier off with a source");
endmodule // mas_core_monitor
`default_nettype wire

// file: tb/mas_adc_model.sv
`timescale 1ns/1ns
`default_nettype none
// ********
// converter model
// ********
module mas_adc_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic conv_start,
	input wire logic conv_abort,
	input wire logic [3:0] conv_channel,
	input wire logic slow,
	output logic conv_done,
	output logic [15:0] conv_data
);
	logic [5:0] left_reg;
	logic [3:0] ch_reg;
	// answers a start after 3 or 30 cycles, drops it on abort
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_reg <= 6'h00;
			ch_reg <= 4'h0;
			conv_done <= 1'h0;
			conv_data <= 16'h0000;
		end else begin
			conv_done <= 1'h0;
			conv_data <= ~conv_data; // no stale value outside done
			if (conv_abort) begin
				left_reg <= 6'h00;
			end else if (conv_start) begin
				left_reg <= slow ? 6'h1E : 6'h03;
				ch_reg <= conv_channel;
			end else if (left_reg == 6'h01) begin
				left_reg <= 6'h00;
				conv_done <= 1'h1;
				conv_data <= {4'h5, ch_reg, 8'hA3};
			end else if (left_reg != 6'h00) begin
				left_reg <= left_reg - 6'h01;
			end
		end
	end
endmodule // mas_adc_model
`default_nettype wire

// file: tb/mas_core_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "mas_defs.vh"
module mas_core_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic adapter_valid_in, bus_valid_in, bat_above_low_in, bat_above_high_in;
	logic battery_only_in, source_detect_busy_in, input_high_impedance_mode_in;
	logic charging_in, charge_fault_suspend_in, trickle_in, supplement_in, charge_disabled_in;
	logic [15:0] alert_status_in, conv_data;
	logic conv_start, conv_abort, conv_done, bias_regulator_output_en, alert_q, oe_q;
	logic current_sense_amplifier_en, indicator_o, indicator_oe, alert_n;
	logic [3:0] conv_channel;
	logic [1:0] conv_speed;
	int fails, samples_checked, cyc, starts, aborts, alerts, flips;
	// ********
	// design and converter
	// ********
	mas_core #(.ALERT_CYC(32'h14), .BLINK_CYC(32'hA)) mas_core_inst (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .adapter_valid_in, .bus_valid_in, .bat_above_low_in, .bat_above_high_in,
		.battery_only_in, .source_detect_busy_in, .input_high_impedance_mode_in,
		.charging_in, .charge_fault_suspend_in, .trickle_in, .supplement_in,
		.charge_disabled_in, .alert_status_in, .conv_start, .conv_abort, .conv_channel,
		.conv_speed, .conv_done, .conv_data, .bias_regulator_output_en,
		.current_sense_amplifier_en, .indicator_o, .indicator_oe, .alert_n);
	mas_adc_model mas_adc_model_inst (.pclk, .presetn, .conv_start, .conv_abort,
		.conv_channel, .slow, .conv_done, .conv_data);
	// clock
	initial begin
		pclk = 1'h0;
		forever #2 pclk = ~pclk;
	end
	// event counters and run limit
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		starts <= starts + conv_start;
		aborts <= aborts + conv_abort;
		alert_q <= alert_n;
		alerts <= alerts + (alert_q & !alert_n);
		oe_q <= indicator_oe;
		flips <= flips + (oe_q ^ indicator_oe);
		if (cyc == 5000) begin
			fails++;
			close_out;
		end
	end
	task close_out;
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wcyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one apb transfer, setup then access until ready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(rd, e);
	endtask
	// reset values and an unmapped read
	task t_regs;
		rdc(`MAS_OFF_CTRL, 32'h0);
		rdc(`MAS_OFF_CHDIS0, 32'h0);
		rdc(`MAS_OFF_CHDIS1, 32'h0);
		rdc(8'h30, 32'h0);
		chk(err, 32'h1);
	endtask
	// enable, supply gating, detection hold, battery levels
	task t_gate;
		int s;
		input_high_impedance_mode_in <= 1'h1;
		adapter_valid_in <= 1'h1;
		wcyc(40);
		chk(starts, 0);
		adapter_valid_in <= 1'h0;
		wr(`MAS_OFF_CTRL, 32'h1);
		wcyc(40);
		chk(starts, 0);
		bat_above_low_in <= 1'h1;
		wcyc(20);
		chk(starts > 0, 1);
		source_detect_busy_in <= 1'h1;
		wcyc(10);
		s = starts;
		wcyc(40);
		chk(starts, s);
		source_detect_busy_in <= 1'h0;
		battery_only_in <= 1'h1;
		wcyc(10);
		s = starts;
		wcyc(40);
		chk(starts, s);
		bat_above_high_in <= 1'h1;
		wcyc(20);
		chk(starts > s, 1);
		bat_above_high_in <= 1'h0;
		wcyc(10);
		s = starts;
		wr(`MAS_OFF_CHDIS1, 32'h4);
		wcyc(20);
		chk(starts > s, 1);
		chk(bias_regulator_output_en, 0);
		wr(`MAS_OFF_CTRL, 32'h0);
		wcyc(10);
		s = starts;
		wcyc(40);
		chk(starts, s);
		battery_only_in <= 1'h0;
		input_high_impedance_mode_in <= 1'h0;
	endtask
	// continuous run, faults, all disabled, speed change
	task t_cont;
		int s, a;
		wr(`MAS_OFF_CHDIS0, 32'hFF);
		wr(`MAS_OFF_CHDIS1, 32'hFB);
		wr(`MAS_OFF_CTRL, 32'h1);
		wcyc(30);
		chk(bias_regulator_output_en, 1);
		rdc(8'h68, {16'h0, 4'h5, 4'hA, 8'hA3});
		rdc(`MAS_OFF_STATUS, 32'h0);
		charge_fault_suspend_in <= 1'h1;
		s = starts;
		wcyc(40);
		chk(starts > s, 1);
		wr(`MAS_OFF_CHDIS1, 32'hFF);
		wcyc(10);
		s = starts;
		wcyc(40);
		chk(starts, s);
		wr(`MAS_OFF_CHDIS1, 32'hFB);
		wcyc(20);
		chk(starts > s, 1);
		slow <= 1'h1;
		s = starts + 1;
		while (starts <= s) @(posedge pclk);
		wcyc(5);
		a = aborts;
		wr(`MAS_OFF_CTRL, 32'h21);
		wcyc(5);
		chk(aborts > a, 1);
		chk(conv_speed, 2'h2);
		wr(`MAS_OFF_CTRL, 32'h0);
		slow <= 1'h0;
		charge_fault_suspend_in <= 1'h0;
	endtask
	// one-shot end: enable cleared, done status, flag, alert
	task t_oneshot;
		int a;
		trickle_in <= 1'h1;
		wr(`MAS_OFF_CHDIS0, 32'hFD);
		a = alerts;
		wr(`MAS_OFF_CTRL, 32'h3);
		wcyc(60);
		rdc(`MAS_OFF_CTRL, 32'h2);
		rdc(8'h44, 32'h0);
		rdc(`MAS_OFF_STATUS, 32'h10000);
		rdc(`MAS_OFF_FLAG, 32'h10000);
		rdc(`MAS_OFF_FLAG, 32'h0);
		chk(alerts, a + 1);
		trickle_in <= 1'h0;
	endtask
	// status rises, merging within a pulse, masking
	task t_alert;
		int a;
		a = alerts;
		alert_status_in <= 16'h0008;
		wcyc(30);
		chk(alerts, a + 1);
		rdc(`MAS_OFF_FLAG, 32'h8);
		alert_status_in <= 16'h0018;
		wcyc(8);
		alert_status_in <= 16'h0038;
		wcyc(30);
		chk(alerts, a + 2);
		rdc(`MAS_OFF_FLAG, 32'h30);
		wr(`MAS_OFF_MASK, 32'h40);
		alert_status_in <= 16'h0078;
		wcyc(30);
		chk(alerts, a + 2);
		rdc(`MAS_OFF_FLAG, 32'h40);
		rdc(`MAS_OFF_STATUS, 32'h10078);
	endtask
	// averaging from stored and fresh seed, bus supply only
	task t_avg;
		bat_above_low_in <= 1'h0;
		bus_valid_in <= 1'h1;
		wr(`MAS_OFF_CHDIS1, 32'hFF);
		wr(`MAS_OFF_CTRL, 32'h7);
		wcyc(40);
		rdc(8'h44, 32'h28D1);
		chk(conv_channel, 32'h1);
		wr(`MAS_OFF_CTRL, 32'h0);
		wr(`MAS_OFF_CTRL, 32'hF);
		wcyc(40);
		rdc(8'h44, 32'h51A3);
		rdc(`MAS_OFF_FLAG, 32'h10000);
		bus_valid_in <= 1'h0;
		bat_above_low_in <= 1'h1;
	endtask
	// indicator pin states, blink and sense amplifier
	task t_ind;
		int f;
		charging_in <= 1'h1;
		wcyc(8);
		chk(indicator_oe, 1);
		input_high_impedance_mode_in <= 1'h1;
		wcyc(8);
		chk(indicator_oe, 0);
		input_high_impedance_mode_in <= 1'h0;
		charge_disabled_in <= 1'h1;
		wcyc(8);
		chk(indicator_oe, 0);
		charge_disabled_in <= 1'h0;
		wr(`MAS_OFF_CTRL, 32'h80);
		wcyc(8);
		chk(indicator_oe, 0);
		wr(`MAS_OFF_CTRL, 32'h0);
		charge_fault_suspend_in <= 1'h1;
		wcyc(10);
		f = flips;
		wcyc(100);
		chk(flips - f, 10);
		battery_only_in <= 1'h1;
		wcyc(8);
		chk(current_sense_amplifier_en, 0);
		wr(`MAS_OFF_CTRL, 32'h40);
		wcyc(4);
		chk(current_sense_amplifier_en, 1);
	endtask
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, slow, adapter_valid_in, bus_valid_in,
			bat_above_low_in, bat_above_high_in, battery_only_in, source_detect_busy_in,
			input_high_impedance_mode_in, charging_in, charge_fault_suspend_in, trickle_in,
			supplement_in, charge_disabled_in, alert_status_in, oe_q} = '0;
		alert_q = 1'h1;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		t_regs;
		t_gate;
		t_cont;
		t_oneshot;
		t_alert;
		t_avg;
		t_ind;
		close_out;
	end
endmodule // mas_core_bench
bind mas_core mas_core_monitor #(.ALERT_CYC(ALERT_CYC)) mas_core_monitor_inst (.pclk, .presetn,
	.conv_start, .source_detect_busy_in, .adapter_valid_in, .bus_valid_in, .bat_above_low_in,
	.charging_in, .charge_fault_suspend_in, .input_high_impedance_mode_in, .battery_only_in,
	.indicator_o, .indicator_oe, .current_sense_amplifier_en, .alert_n);
`default_nettype wire
